/* File: pkg/pmt_map.vh */
// register offsets, field positions and reset values of the period timer
`ifndef PMT_MAP_VH
`define PMT_MAP_VH

// register offsets on the plain register port
`define PMT_ADDR_W        3
`define PMT_OFF_COUNT     3'h0
`define PMT_OFF_PERIOD    3'h1
`define PMT_OFF_CTRL      3'h2
`define PMT_OFF_IRQFLAGS  3'h3
`define PMT_OFF_IRQENA    3'h4

// control register fields
`define PMT_CTRL_PRE_LSB  0
`define PMT_CTRL_PRE_MSB  1
`define PMT_CTRL_POST_LSB 3
`define PMT_CTRL_POST_MSB 6

// interrupt flag and enable bit
`define PMT_IRQ_MATCH_BIT 0

// reset values
`define PMT_RST_COUNT     8'h00
`define PMT_RST_PERIOD    8'hFF
`define PMT_RST_CTRL      8'h00
`define PMT_RST_IRQENA    8'h00

// instruction clock is the oscillator clock divided by this
`define PMT_FOSC_DIV      4
`define PMT_PHASE_LAST    2'h3

// prescale select codes and division end points
`define PMT_PRE_DIV1      2'h0
`define PMT_PRE_DIV4      2'h1
`define PMT_PRE_END4      2'h3
`define PMT_PRE_END16     4'hF

`endif

/* File: hdl/pmt_timer.v */
// period match timer with prescaler, postscaler and interrupt flag
//
// Notes on behaviour
// - timer runs on instruction clock, oscillator clock divided by four
// - count starts at zero, advances one per prescaler tick
// - four-bit prescale counter sits on the instruction clock input
// - prescale select picks divide by one, four or sixteen
// - count compared with period; equality gives the match pulse
// - after a match count goes to zero; match feeds postscaler
// - software reads and writes count and period at any time
// - any reset clears count and sets period to all ones
// - count or control write clears both scalers; control write keeps count
// - all device reset sources clear prescale and postscale counters
// - match pulse drives a four-bit postscale counter
// - postscale completion sets sticky match flag until software clears it
// - interrupt raised only while the match enable bit is set
// - postscale select gives sixteen ratios, one to sixteen
// - match pulse is synchronous to the system clock
// - during sleep timer stops; count and period hold
//
// Implementation choices: the address-and-strobe port and the register offsets.
`include "pmt_map.vh"

module pmt_timer #(
  parameter DATA_W = 8
) (
  // clock and reset
  input  wire              clk,
  input  wire              rst,
  // power state from the core
  input  wire              sleepMode,
  // register port
  input  wire [`PMT_ADDR_W-1:0] regAddr,
  input  wire [DATA_W-1:0] regWdata,
  input  wire              regWr,
  input  wire              regRd,
  output wire [DATA_W-1:0] regRdata,
  // timer output and interrupt
  output wire              periodMatchPulse,
  output wire              irqOut
);

  //////////////////////////////////////////////////////////////////////////
  // registers and decode

  reg  [1:0]        phaseQ;
  reg  [3:0]        preQ;
  reg  [3:0]        postQ;
  reg  [DATA_W-1:0] countQ;
  reg  [DATA_W-1:0] periodQ;
  reg  [DATA_W-1:0] ctrlQ;
  reg               matchFlagQ;
  reg  [DATA_W-1:0] irqEnaQ;
  reg               matchQ;
  reg  [DATA_W-1:0] rdataQ;

  reg  [DATA_W-1:0] rdata_d;
  reg               preTick;

  wire wrCount  = regWr && (regAddr == `PMT_OFF_COUNT);
  wire wrPeriod = regWr && (regAddr == `PMT_OFF_PERIOD);
  wire wrCtrl   = regWr && (regAddr == `PMT_OFF_CTRL);
  wire wrIrqEna = regWr && (regAddr == `PMT_OFF_IRQENA);
  wire rdFlags  = regRd && (regAddr == `PMT_OFF_IRQFLAGS);

  // either write restarts both scalers so the new setting starts clean
  wire scalerClr = wrCount || wrCtrl;

  wire [1:0] preSel  = ctrlQ[`PMT_CTRL_PRE_MSB:`PMT_CTRL_PRE_LSB];
  wire [3:0] postSel = ctrlQ[`PMT_CTRL_POST_MSB:`PMT_CTRL_POST_LSB];

  // instruction clock edge: one cycle in every four, frozen in sleep
  wire instrTick = (phaseQ == `PMT_PHASE_LAST) && !sleepMode;

  // count equals period on a qualified edge
  wire hit = preTick && (countQ == periodQ);

  //////////////////////////////////////////////////////////////////////////
  // instruction clock divider

  // phase runs whenever not in sleep and ignores register writes, so instruction cycles keep their rhythm
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      phaseQ <= 2'h0;
    end else if (!sleepMode) begin
      phaseQ <= phaseQ + 2'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // prescaler

  // prescaler output tick chosen from the four-bit counter
  always @* begin
    preTick = 1'b0;
    if (instrTick && !scalerClr) begin
      case (preSel)
        `PMT_PRE_DIV1: preTick = 1'b1;
        `PMT_PRE_DIV4: preTick = (preQ[1:0] == `PMT_PRE_END4);
        default:       preTick = (preQ == `PMT_PRE_END16);
      endcase
    end
  end

  // four-bit counter clocked by the instruction clock
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      preQ <= 4'h0;
    end else if (scalerClr) begin
      preQ <= 4'h0;
    end else if (instrTick) begin
      preQ <= preQ + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // count register

  // software write wins over the timer advance in the same cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      countQ <= `PMT_RST_COUNT;
    end else if (wrCount) begin
      countQ <= regWdata;
    end else if (hit) begin
      countQ <= `PMT_RST_COUNT;
    end else if (preTick) begin
      countQ <= countQ + {{(DATA_W-1){1'b0}}, 1'b1};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // period and control registers

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      periodQ <= `PMT_RST_PERIOD;
      ctrlQ   <= `PMT_RST_CTRL;
      irqEnaQ <= `PMT_RST_IRQENA;
    end else begin
      if (wrPeriod) begin
        periodQ <= regWdata;
      end
      if (wrCtrl) begin
        ctrlQ <= regWdata;
      end
      if (wrIrqEna) begin
        irqEnaQ <= regWdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // match pulse

  // registered so it is a clean one-cycle pulse on clk
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      matchQ <= 1'b0;
    end else begin
      matchQ <= hit;
    end
  end

  assign periodMatchPulse = matchQ;

  //////////////////////////////////////////////////////////////////////////
  // postscaler

  // counts match pulses; select n completes after n plus one of them
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      postQ <= 4'h0;
    end else if (scalerClr) begin
      postQ <= 4'h0;
    end else if (matchQ) begin
      if (postQ == postSel) begin
        postQ <= 4'h0;
      end else begin
        postQ <= postQ + 4'h1;
      end
    end
  end

  wire postDone = matchQ && !scalerClr && (postQ == postSel);

  //////////////////////////////////////////////////////////////////////////
  // interrupt flag

  // read of the flag register clears it; a new event in that cycle wins
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      matchFlagQ <= 1'b0;
    end else if (postDone) begin
      matchFlagQ <= 1'b1;
    end else if (rdFlags) begin
      matchFlagQ <= 1'b0;
    end
  end

  // level request only while the enable bit is set
  assign irqOut = matchFlagQ && irqEnaQ[`PMT_IRQ_MATCH_BIT];

  //////////////////////////////////////////////////////////////////////////
  // read path

  // unmapped offsets read as zero; flag read shows value before clearing
  always @* begin
    rdata_d = {DATA_W{1'b0}};
    case (regAddr)
      `PMT_OFF_COUNT:    rdata_d = countQ;
      `PMT_OFF_PERIOD:   rdata_d = periodQ;
      `PMT_OFF_CTRL:     rdata_d = ctrlQ;
      `PMT_OFF_IRQFLAGS: rdata_d[`PMT_IRQ_MATCH_BIT] = matchFlagQ;
      `PMT_OFF_IRQENA:   rdata_d = irqEnaQ;
      default:           rdata_d = {DATA_W{1'b0}};
    endcase
  end

  // data held until the next read strobe
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdataQ <= {DATA_W{1'b0}};
    end else if (regRd) begin
      rdataQ <= rdata_d;
    end
  end

  assign regRdata = rdataQ;

endmodule

/* File: testbench/pmt_checker.sv */
// port checks on the period match timer
module pmt_checker (
  // clock and reset
  input logic       clk,
  input logic       rst,
  // power state and register port
  input logic       sleepMode,
  input logic [2:0] regAddr,
  input logic [7:0] regWdata,
  input logic       regWr,
  input logic       regRd,
  input logic [7:0] regRdata,
  // timer output and interrupt
  input logic       periodMatchPulse,
  input logic       irqOut
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // write, idle cycle, read of the same place
  sequence wr_rd(a);
    regWr && regAddr == a ##2 regRd && regAddr == a;
  endsequence
  // only places hardware never changes, count may tick
  property wr_back(a);
    wr_rd(a) |=> regRdata == $past(regWdata, 3);
  endproperty
  ////////////////////////////////////////////////////////////////////////
  pulse_single_a: assert property (
    periodMatchPulse |=> !periodMatchPulse [*3])
    else $error("match pulse too close");
  sleep_quiet_a: assert property (
    sleepMode |=> !periodMatchPulse)
    else $error("pulse while asleep");
  unmapped_zero_a: assert property (
    regRd && regAddr > 3'h4 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (
    !regRd |=> $stable(regRdata))
    else $error("read data moved");
  period_back_a: assert property (wr_back(3'h1))
    else $error("period read back wrong");
  ctrl_back_a: assert property (wr_back(3'h2))
    else $error("control read back wrong");
  flag_read_a: assert property (
    regRd && regAddr == 3'h3 && irqOut |=> regRdata[0])
    else $error("flag missing in read");
  flag_clear_a: assert property (
    regRd && regAddr == 3'h3 && !periodMatchPulse |=> !irqOut)
    else $error("flag not cleared by read");
  irq_cause_a: assert property (
    $rose(irqOut) && !$past(regWr) |-> $past(periodMatchPulse))
    else $error("interrupt without match");
endmodule

bind pmt_timer pmt_checker pmt_checker_inst (.clk, .rst, .sleepMode,
  .regAddr, .regWdata, .regWr, .regRd, .regRdata, .periodMatchPulse,
  .irqOut);

/* File: testbench/tb_period_match_timer.sv */
// self-checking bench for the period match timer
module tb_period_match_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, rst = 1, sleepMode = 1, regWr = 0, regRd = 0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00, regRdata;
  logic       periodMatchPulse, irqOut;
  int         errors = 0, checks_done = 0, n;
  // 25 MHz clock
  always #20 clk = ~clk;
  pmt_timer pmt_timer_inst (.clk(clk), .rst(rst), .sleepMode(sleepMode),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .periodMatchPulse(periodMatchPulse),
    .irqOut(irqOut));
  ////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one-cycle strobes, launched just after a rising edge
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rdChk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    chk(regRdata, exp);
  endtask
  // cycles until the next match pulse, bounded
  task automatic waitPulse;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 900) begin
        errors++;
        results();
      end
    end while (periodMatchPulse !== 1'b1);
  endtask
  task automatic sleep(input logic v);
    @(posedge clk);
    sleepMode <= v;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // asleep: reset values, read back, control write keeps count
  task automatic regScenario;
    rdChk(3'h0, 8'h00);
    rdChk(3'h1, 8'hFF);
    rdChk(3'h5, 8'h00);
    wr(3'h1, 8'h5A);
    rdChk(3'h1, 8'h5A);
    wr(3'h0, 8'h33);
    wr(3'h2, 8'h7B);
    rdChk(3'h2, 8'h7B);
    repeat (40) @(posedge clk);
    rdChk(3'h0, 8'h33);
  endtask
  // gap between pulses is 4 * divide * (period + 1) clocks
  task automatic preScenario;
    int div[4] = '{1, 4, 16, 16};
    sleep(1'b0);
    wr(3'h1, 8'h02);
    for (int c = 0; c < 4; c++) begin
      wr(3'h2, {6'h00, c[1:0]});
      wr(3'h0, 8'h00);
      waitPulse();
      waitPulse();
      chk(8'(n), 8'(12 * div[c]));
    end
    // postscale 1:1 left the flag set; reading it clears it
    sleep(1'b1);
    rdChk(3'h3, 8'h01);
  endtask
  // setup asleep so no stray pulse sets the flag early
  task automatic postScenario(input logic [3:0] p, input logic en);
    sleep(1'b1);
    wr(3'h4, {7'h00, en});
    wr(3'h1, 8'h00);
    wr(3'h2, {1'b0, p, 3'h0});
    wr(3'h0, 8'h00);
    rdChk(3'h3, 8'h00);
    sleep(1'b0);
    repeat (p) waitPulse();
    @(negedge clk);
    chk({7'h00, irqOut}, 8'h00);
    waitPulse();
    @(negedge clk);
    chk({7'h00, irqOut}, {7'h00, en});
    sleep(1'b1);
    repeat (2) @(posedge clk);
    rdChk(3'h3, 8'h01);
    chk({7'h00, irqOut}, 8'h00);
  endtask
  // reset while asleep after the runs brings back the count, period and control reset values
  task automatic resetScenario;
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rdChk(3'h0, 8'h00);
    rdChk(3'h1, 8'hFF);
    rdChk(3'h2, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    regScenario();
    preScenario();
    postScenario(4'h0, 1'b1);
    postScenario(4'h3, 1'b1);
    postScenario(4'hF, 1'b0);
    resetScenario();
    results();
  end
endmodule
